// ---- inc/block_ram_pkg.sv ----
// package: constants and types for the dual-port block memory
package block_ram_pkg;

  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W   = 14;
  localparam int DATA_W   = 36;
  localparam int WORD_AW  = 9;
  localparam int LANE_W   = 9;
  localparam int LANES    = 4;
  localparam int BUS_W    = 32;
  localparam int REG_AW   = 5;
  localparam int CFG_W    = 8;
  localparam int PACKED_W = 32;

  // bits per port word and word-index shift, indexed by width code
  localparam int WIDTH_BITS [0:7] = '{1, 2, 4, 9, 18, 36, 0, 0};
  localparam int WORD_SHIFT [0:7] = '{5, 4, 3, 2, 1, 0, 0, 0};

  typedef enum logic [2:0] {
    W1  = 3'h0,
    W2  = 3'h1,
    W4  = 3'h2,
    W9  = 3'h3,
    W18 = 3'h4,
    W36 = 3'h5
  } width_t;

  typedef enum logic [1:0] {
    WM_NORMAL  = 2'h0,
    WM_THROUGH = 2'h1,
    WM_RBW     = 2'h2
  } wmode_t;

  typedef enum logic [1:0] {
    PM_SINGLE = 2'h0,
    PM_TRUE   = 2'h1,
    PM_PSEUDO = 2'h2
  } pmode_t;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [4:0] CFG_A_OFS  = 5'h00;
  localparam logic [4:0] CFG_B_OFS  = 5'h04;
  localparam logic [4:0] CTRL_OFS   = 5'h08;
  localparam logic [4:0] IADDR_OFS  = 5'h0c;
  localparam logic [4:0] ILO_OFS    = 5'h10;
  localparam logic [4:0] IHI_OFS    = 5'h14;
  localparam logic [4:0] STATUS_OFS = 5'h18;

  // ----------------------------------------------------------------
  // fields
  // ----------------------------------------------------------------
  localparam int CFG_WIDTH_LSB = 0;
  localparam int CFG_WMODE_LSB = 3;
  localparam int CFG_OREG_BIT  = 5;
  localparam int CFG_ASYNC_BIT = 6;
  localparam int CFG_PAR_BIT   = 7;
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_RUN_BIT  = 4;
  localparam int IHI_W         = 4;
  localparam int ST_RUN_BIT    = 0;
  localparam int ST_ERR_A_BIT  = 1;
  localparam int ST_ERR_B_BIT  = 2;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] CFG_RST  = 8'h03;
  localparam logic [1:0] MODE_RST = 2'h1;
  localparam logic       RUN_RST  = 1'b0;

endpackage : block_ram_pkg

// ---- src/block_ram_array.sv ----
// storage array: 512 words of 36 bits, two ports, bit-masked writes
`timescale 1ns/1ns
module block_ram_array (
  input  wire logic        clock,
  input  wire logic        en_a,
  input  wire logic [8:0]  addr_a,
  input  wire logic [35:0] wmask_a,
  input  wire logic [35:0] din_a,
  output logic      [35:0] q_a,
  input  wire logic        en_b,
  input  wire logic [8:0]  addr_b,
  input  wire logic [35:0] wmask_b,
  input  wire logic [35:0] din_b,
  output logic      [35:0] q_b
);

  logic [35:0] mem [0:511];

  // read returns the word as it stood before this edge, which gives
  // read-before-write for free; on a same-word collision port a wins
  always_ff @(posedge clock) begin
    if (en_b) begin
      mem[addr_b] <= (mem[addr_b] & ~wmask_b) | (din_b & wmask_b);
      q_b         <= mem[addr_b];
    end
    if (en_a) begin
      mem[addr_a] <= (mem[addr_a] & ~wmask_a) | (din_a & wmask_a);
      q_a         <= mem[addr_a];
    end
  end

endmodule : block_ram_array

// ---- src/embedded_block_memory.sv ----
// dual-port block memory: port pipelines, output latches, config port
`timescale 1ns/1ns
module embedded_block_memory (
  input  wire logic        clock,
  input  wire logic        sys_rst,
  input  wire logic        chip_wide_clear_low,
  input  wire logic        port_a_output_clear,
  input  wire logic        port_b_output_clear,
  input  wire logic        ce_a,
  input  wire logic        we_a,
  input  wire logic [3:0]  be_a,
  input  wire logic [13:0] addr_a,
  input  wire logic [35:0] din_a,
  output logic      [35:0] dout_a,
  input  wire logic        ce_b,
  input  wire logic        we_b,
  input  wire logic [3:0]  be_b,
  input  wire logic [13:0] addr_b,
  input  wire logic [35:0] din_b,
  output logic      [35:0] dout_b,
  input  wire logic [4:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        vld;
    logic        we;
    logic        rd;
    logic [2:0]  w;
    logic [13:0] a;
    logic [35:0] din;
    logic [1:0]  wm;
    logic        par;
    logic [35:0] lat;
    logic [35:0] q;
  } port_t;

  typedef struct packed {
    logic [1:0][7:0] cfg;
    logic [1:0]      pmode;
    logic            run;
    logic [8:0]      iaddr;
    logic [31:0]     ilo;
    logic [31:0]     rdata;
    port_t [1:0]     p;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  // per-port views of the pins
  logic [1:0]       ce;
  logic [1:0]       we;
  logic [1:0]       clr;
  logic [1:0][3:0]  be;
  logic [1:0][13:0] addr;
  logic [1:0][35:0] din;
  logic [1:0]       legal;
  logic [1:0]       err;
  logic [1:0][2:0]  wid;
  logic [1:0][1:0]  wm;
  logic [1:0]       oreg;
  logic [1:0]       asy;
  logic [1:0]       par;

  // array side
  logic [1:0]       men;
  logic [1:0][8:0]  mword;
  logic [1:0][35:0] mmask;
  logic [1:0][35:0] mdata;
  logic [1:0][35:0] mq;
  logic             init_we;

  assign ce   = {ce_b, ce_a};
  assign we   = {we_b, we_a};
  assign clr  = {port_b_output_clear, port_a_output_clear};
  assign be   = {be_b, be_a};
  assign addr = {addr_b, addr_a};
  assign din  = {din_b, din_a};

  // ----------------------------------------------------------------
  // lane mapping
  // ----------------------------------------------------------------
  // physical word: four 9-bit lanes, bit 8 of a lane is its parity bit;
  // narrow widths pack into the 32 data bits, lowest word first
  function automatic logic [71:0] place(logic [2:0] w, logic [13:0] a,
                                        logic [35:0] d, logic [3:0] b,
                                        logic pe);
    logic [35:0] m;
    logic [35:0] v;
    int          wd;
    int          nl;
    int          off;
    int          first;
    int          idx;
    int          byt;
    int          bt;
    m     = '0;
    v     = '0;
    wd    = block_ram_pkg::WIDTH_BITS[w];
    nl    = wd / block_ram_pkg::LANE_W;
    off   = (int'(a) * wd) % block_ram_pkg::PACKED_W;
    first = (int'(a) * nl) % block_ram_pkg::LANES;
    for (int p = 0; p < block_ram_pkg::DATA_W; p++) begin
      byt = p / block_ram_pkg::LANE_W;
      bt  = p % block_ram_pkg::LANE_W;
      if (wd < block_ram_pkg::LANE_W) begin
        idx = byt * 8 + bt - off;
        if (bt != 8 && idx >= 0 && idx < wd) begin
          m[p] = 1'b1;
          v[p] = d[idx];
        end
      end else begin
        idx = byt - first;
        if (idx >= 0 && idx < nl && (nl == 1 || b[idx])) begin
          m[p] = 1'b1;
          v[p] = (bt == 8 && !pe) ? 1'b0 : d[idx * 9 + bt];
        end
      end
    end
    return {m, v};
  endfunction : place

  function automatic logic [35:0] extract(logic [2:0] w, logic [13:0] a,
                                          logic [35:0] word, logic pe);
    logic [35:0] o;
    int          wd;
    int          nl;
    int          off;
    int          first;
    int          idx;
    int          byt;
    int          bt;
    o     = '0;
    wd    = block_ram_pkg::WIDTH_BITS[w];
    nl    = wd / block_ram_pkg::LANE_W;
    off   = (int'(a) * wd) % block_ram_pkg::PACKED_W;
    first = (int'(a) * nl) % block_ram_pkg::LANES;
    for (int p = 0; p < block_ram_pkg::DATA_W; p++) begin
      byt = p / block_ram_pkg::LANE_W;
      bt  = p % block_ram_pkg::LANE_W;
      if (wd < block_ram_pkg::LANE_W) begin
        idx = byt * 8 + bt - off;
        if (bt != 8 && idx >= 0 && idx < wd) begin
          o[idx] = word[p];
        end
      end else begin
        idx = byt - first;
        if (idx >= 0 && idx < nl) begin
          o[idx * 9 + bt] = (bt == 8 && !pe) ? 1'b0 : word[p];
        end
      end
    end
    return o;
  endfunction : extract

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [71:0] pl;
    logic [35:0] lat_n;
    logic        wr_ok;
    logic        rd_ok;
    logic        clr_now;
    pl      = '0;
    lat_n   = '0;
    wr_ok   = 1'b0;
    rd_ok   = 1'b0;
    clr_now = 1'b0;
    st_nxt  = st_r;
    init_we = 1'b0;
    st_nxt.rdata = '0;

    // config decode, each port has its own width and options
    for (int i = 0; i < 2; i++) begin
      wid[i]  = st_r.cfg[i][block_ram_pkg::CFG_WIDTH_LSB +: 3];
      wm[i]   = st_r.cfg[i][block_ram_pkg::CFG_WMODE_LSB +: 2];
      oreg[i] = st_r.cfg[i][block_ram_pkg::CFG_OREG_BIT];
      asy[i]  = st_r.cfg[i][block_ram_pkg::CFG_ASYNC_BIT];
      par[i]  = st_r.cfg[i][block_ram_pkg::CFG_PAR_BIT];
      err[i]  = wid[i] > block_ram_pkg::W36
             || st_r.pmode > block_ram_pkg::PM_PSEUDO
             || (st_r.pmode == block_ram_pkg::PM_TRUE
                 && wid[i] == block_ram_pkg::W36);
      legal[i] = st_r.run && !err[i]
              && (i == 0 || st_r.pmode != block_ram_pkg::PM_SINGLE);
    end

    // register port writes
    if (reg_wr) begin
      case (reg_addr)
        block_ram_pkg::CFG_A_OFS: st_nxt.cfg[0] = reg_wdata[7:0];
        block_ram_pkg::CFG_B_OFS: st_nxt.cfg[1] = reg_wdata[7:0];
        block_ram_pkg::CTRL_OFS: begin
          st_nxt.pmode = reg_wdata[block_ram_pkg::CTRL_MODE_LSB +: 2];
          st_nxt.run   = reg_wdata[block_ram_pkg::CTRL_RUN_BIT];
        end
        block_ram_pkg::IADDR_OFS: st_nxt.iaddr = reg_wdata[8:0];
        block_ram_pkg::ILO_OFS:   st_nxt.ilo   = reg_wdata;
        block_ram_pkg::IHI_OFS: begin
          // preload only while user operation is held off
          if (!st_r.run) begin
            init_we      = 1'b1;
            st_nxt.iaddr = st_r.iaddr + 9'h001;
          end
        end
        default: ;
      endcase
    end

    // register port reads, data valid in the next cycle only
    if (reg_rd) begin
      case (reg_addr)
        block_ram_pkg::CFG_A_OFS:  st_nxt.rdata = {24'h00_0000, st_r.cfg[0]};
        block_ram_pkg::CFG_B_OFS:  st_nxt.rdata = {24'h00_0000, st_r.cfg[1]};
        block_ram_pkg::CTRL_OFS:   st_nxt.rdata = {27'h000_0000, st_r.run, 2'h0,
                                                   st_r.pmode};
        block_ram_pkg::IADDR_OFS:  st_nxt.rdata = {23'h00_0000, st_r.iaddr};
        block_ram_pkg::ILO_OFS:    st_nxt.rdata = st_r.ilo;
        block_ram_pkg::STATUS_OFS: st_nxt.rdata = {29'h0000_0000, err, st_r.run};
        default:                   st_nxt.rdata = '0;
      endcase
    end

    // port pipelines
    for (int i = 0; i < 2; i++) begin
      // pseudo dual: a writes only, b reads only
      wr_ok = legal[i] && we[i]
           && !(st_r.pmode == block_ram_pkg::PM_PSEUDO && i == 1);
      rd_ok = legal[i] && !we[i]
           && !(st_r.pmode == block_ram_pkg::PM_PSEUDO && i == 0);
      pl = place(wid[i], addr[i], din[i], be[i], par[i]);

      men[i]   = ce[i] && legal[i];
      mword[i] = 9'(addr[i] >> block_ram_pkg::WORD_SHIFT[wid[i]]);
      mmask[i] = wr_ok ? pl[71:36] : '0;
      mdata[i] = pl[35:0];

      // input stage, taken only with the port enable
      if (ce[i]) begin
        st_nxt.p[i].vld = wr_ok || rd_ok;
        st_nxt.p[i].we  = wr_ok;
        st_nxt.p[i].rd  = rd_ok;
        st_nxt.p[i].w   = wid[i];
        st_nxt.p[i].a   = addr[i];
        st_nxt.p[i].din = din[i];
        st_nxt.p[i].wm  = wm[i];
        st_nxt.p[i].par = par[i];
      end

      // output latch, advances only with the port enable
      lat_n = st_r.p[i].lat;
      if (ce[i] && st_r.p[i].vld) begin
        if (st_r.p[i].we) begin
          if (st_r.p[i].wm == block_ram_pkg::WM_THROUGH) begin
            lat_n = st_r.p[i].din
                  & ((36'h0_0000_0001 << block_ram_pkg::WIDTH_BITS[st_r.p[i].w])
                     - 36'h0_0000_0001);
          end else if (st_r.p[i].wm == block_ram_pkg::WM_RBW
                       && st_r.p[i].w >= block_ram_pkg::W9) begin
            lat_n = extract(st_r.p[i].w, st_r.p[i].a, mq[i], st_r.p[i].par);
          end
          // normal mode, and rbw on narrow widths, hold the latch
        end else if (st_r.p[i].rd) begin
          lat_n = extract(st_r.p[i].w, st_r.p[i].a, mq[i], st_r.p[i].par);
        end
      end

      // async clears act without the enable, sync ones need it
      clr_now = (clr[i] || !chip_wide_clear_low) && (asy[i] || ce[i]);
      if (clr_now) begin
        st_nxt.p[i].lat = '0;
        st_nxt.p[i].q   = '0;
      end else begin
        st_nxt.p[i].lat = lat_n;
        if (ce[i]) begin
          st_nxt.p[i].q = oreg[i] ? st_r.p[i].lat : lat_n;
        end
      end
    end

    // preload borrows port a; user traffic is blocked until run is set
    if (init_we) begin
      men[0]   = 1'b1;
      mword[0] = st_r.iaddr;
      mmask[0] = '1;
      mdata[0] = {reg_wdata[block_ram_pkg::IHI_W-1:0], st_r.ilo};
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      st_r       <= '0;
      st_r.cfg   <= {block_ram_pkg::CFG_RST, block_ram_pkg::CFG_RST};
      st_r.pmode <= block_ram_pkg::MODE_RST;
      st_r.run   <= block_ram_pkg::RUN_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign dout_a    = st_r.p[0].q;
  assign dout_b    = st_r.p[1].q;
  assign reg_rdata = st_r.rdata;

  block_ram_array u_array (
    .clock   (clock),
    .en_a    (men[0]),
    .addr_a  (mword[0]),
    .wmask_a (mmask[0]),
    .din_a   (mdata[0]),
    .q_a     (mq[0]),
    .en_b    (men[1]),
    .addr_b  (mword[1]),
    .wmask_b (mmask[1]),
    .din_b   (mdata[1]),
    .q_b     (mq[1])
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  sequence s_quiet_a;
    ce_a && !port_a_output_clear && chip_wide_clear_low && !reg_wr;
  endsequence

  sequence s_write_a(logic [1:0] mode);
    s_quiet_a and (we_a && legal[0] && wm[0] == mode);
  endsequence

  a_input_reg: assert property (ce_a |=> st_r.p[0].a == $past(addr_a))
    else $error("port a address not captured");

  a_through_data: assert property (
    (s_write_a(block_ram_pkg::WM_THROUGH) and (wid[0] >= block_ram_pkg::W9 && !oreg[0]))
      ##1 s_quiet_a |=> dout_a[8:0] == $past(din_a[8:0], 2))
    else $error("write-through data missing");

  a_normal_hold: assert property (
    s_write_a(block_ram_pkg::WM_NORMAL) ##1 s_quiet_a |=> $stable(st_r.p[0].lat))
    else $error("normal write changed output latch");

  a_rbw_narrow: assert property (
    (s_write_a(block_ram_pkg::WM_RBW) and (wid[0] < block_ram_pkg::W9))
      ##1 s_quiet_a |=> $stable(st_r.p[0].lat))
    else $error("read-before-write on narrow width");

  a_ce_freeze: assert property (
    !ce_a && !port_a_output_clear && chip_wide_clear_low |=> $stable(dout_a))
    else $error("port a output moved without enable");

  a_local_clear: assert property (
    port_a_output_clear && ce_a && chip_wide_clear_low
      && !port_b_output_clear && !ce_b |=> dout_a == '0 && $stable(dout_b))
    else $error("local clear misbehaved");

  a_global_clear: assert property (
    !chip_wide_clear_low && (ce_a || asy[0]) && (ce_b || asy[1])
      |=> dout_a == '0 && dout_b == '0)
    else $error("chip clear missed a port");

  a_async_clear: assert property (
    port_a_output_clear && !ce_a && asy[0] |=> dout_a == '0)
    else $error("async clear needed the enable");

  a_true_no36: assert property (
    ce_a && st_r.pmode == block_ram_pkg::PM_TRUE
      && wid[0] == block_ram_pkg::W36 |=> !st_r.p[0].vld)
    else $error("x36 accepted in true dual mode");

endmodule : embedded_block_memory

// ---- test/fabric_port_model.sv ----
// fabric-side driver for one memory port
`timescale 1ns/1ns
module fabric_port_model (
  input  wire logic        clock,
  output logic             ce,
  output logic             we,
  output logic [3:0]       be,
  output logic [13:0]      addr,
  output logic [35:0]      din,
  input  wire logic [35:0] dout
);
  initial begin
    ce   = 1'b0;
    we   = 1'b0;
    be   = 4'h0;
    addr = 14'h0000;
    din  = 36'h0_0000_0000;
  end

  // one request, then read-only enable cycles so the pipeline walks on;
  // idle address and data carry the inverse of the last value; be keeps its stale copy
  task automatic op(input logic w, input logic [13:0] a, input logic [35:0] d,
                    input logic [3:0] e, input int n, output logic [35:0] q);
    @(posedge clock);
    ce   <= 1'b1;
    we   <= w;
    addr <= a;
    din  <= d;
    be   <= e;
    repeat (n) begin
      @(posedge clock);
      we <= 1'b0;
    end
    ce   <= 1'b0;
    addr <= ~a;
    din  <= ~d;
    #1 q = dout;
  endtask : op
endmodule : fabric_port_model

// ---- test/tb_top.sv ----
// self-checking bench for the dual-port block memory
`timescale 1ns/1ns
module tb_top;
  localparam int TD = int'(block_ram_pkg::PM_TRUE);
  localparam int PS = int'(block_ram_pkg::PM_PSEUDO);
  localparam int SP = int'(block_ram_pkg::PM_SINGLE);
  localparam logic [35:0] Z = 36'h0_0000_0000;
  logic        clock = 1'b0;
  logic        sys_rst = 1'b1;
  logic        chip_wide_clear_low = 1'b1;
  logic        port_a_output_clear = 1'b0;
  logic        port_b_output_clear = 1'b0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [4:0]  reg_addr = 5'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic [31:0] reg_rdata, rd;
  logic        ce_a, we_a, ce_b, we_b;
  logic [3:0]  be_a, be_b;
  logic [13:0] addr_a, addr_b;
  logic [35:0] din_a, din_b, dout_a, dout_b, q, qb;
  logic [35:0] mem [0:511];
  int          n_fail = 0;
  int          total_checks = 0;
  int          cycles = 0;

  always #25 clock = ~clock;

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_fail++;
      test_done();
    end
  end

  embedded_block_memory embedded_block_memory_inst (
    .clock(clock), .sys_rst(sys_rst), .chip_wide_clear_low(chip_wide_clear_low),
    .port_a_output_clear(port_a_output_clear), .port_b_output_clear(port_b_output_clear),
    .ce_a(ce_a), .we_a(we_a), .be_a(be_a), .addr_a(addr_a), .din_a(din_a), .dout_a(dout_a),
    .ce_b(ce_b), .we_b(we_b), .be_b(be_b), .addr_b(addr_b), .din_b(din_b), .dout_b(dout_b),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata)
  );
  fabric_port_model fabric_port_model_a_inst (
    .clock(clock), .ce(ce_a), .we(we_a), .be(be_a), .addr(addr_a), .din(din_a), .dout(dout_a)
  );
  fabric_port_model fabric_port_model_b_inst (
    .clock(clock), .ce(ce_b), .we(we_b), .be(be_b), .addr(addr_b), .din(din_b), .dout(dout_b)
  );

  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : test_done

  task automatic chk(input string nm, input logic [35:0] e, input logic [35:0] g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic rw(input logic [4:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : rw

  task automatic rr(input logic [4:0] a, output logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rr

  task automatic opa(input logic w, input int a, input logic [35:0] d, input logic [3:0] e,
                     input int n);
    fabric_port_model_a_inst.op(w, 14'(a), d, e, n, q);
  endtask : opa

  task automatic opb(input logic w, input int a, input logic [35:0] d, input int n);
    fabric_port_model_b_inst.op(w, 14'(a), d, 4'hf, n, qb);
  endtask : opb

  function automatic logic [31:0] cf(input int w, input int m, input int o, input int s,
                                     input int p);
    return 32'(w | (m << block_ram_pkg::CFG_WMODE_LSB) | (o << block_ram_pkg::CFG_OREG_BIT)
      | (s << block_ram_pkg::CFG_ASYNC_BIT) | (p << block_ram_pkg::CFG_PAR_BIT));
  endfunction : cf

  // ports are reconfigured only while stopped, then restarted
  task automatic setup(input logic [31:0] a, input logic [31:0] b, input int md);
    rw(block_ram_pkg::CTRL_OFS, 32'(md));
    rw(block_ram_pkg::CFG_A_OFS, a);
    rw(block_ram_pkg::CFG_B_OFS, b);
    rw(block_ram_pkg::CTRL_OFS, 32'(md | (1 << block_ram_pkg::CTRL_RUN_BIT)));
  endtask : setup

  // narrow widths skip the parity position of each byte; x9 and wider map lanes directly
  function automatic logic [35:0] xp(input int c, input int a, input logic par);
    int          b;
    int          s;
    int          p;
    logic [35:0] r;
    b = block_ram_pkg::WIDTH_BITS[c];
    s = block_ram_pkg::WORD_SHIFT[c];
    r = Z;
    for (int i = 0; i < b; i++) begin
      p = (b < 9) ? (a % (32 / b)) * b + i : b * (a % (1 << s)) + i;
      r[i] = (b < 9) ? mem[a >> s][p + p / 8] : mem[a >> s][p];
      if (b >= 9 && i % 9 == 8 && !par) r[i] = 1'b0;
    end
    return r;
  endfunction : xp

  function automatic void put(input int c, input int a, input logic [35:0] d,
                              input logic [3:0] e, input logic par);
    int b;
    int s;
    int p;
    b = block_ram_pkg::WIDTH_BITS[c];
    s = block_ram_pkg::WORD_SHIFT[c];
    for (int i = 0; i < b; i++) begin
      p = (b < 9) ? (a % (32 / b)) * b + i : b * (a % (1 << s)) + i;
      if (b < 9) mem[a >> s][p + p / 8] = d[i];
      else if (b == 9 || e[i / 9]) mem[a >> s][p] = (i % 9 == 8 && !par) ? 1'b0 : d[i];
    end
  endfunction : put

  task automatic pulse(input int s);
    @(posedge clock);
    port_a_output_clear <= (s == 0);
    port_b_output_clear <= (s == 1);
    chip_wide_clear_low <= (s != 2);
    @(posedge clock);
    port_a_output_clear <= 1'b0;
    port_b_output_clear <= 1'b0;
    chip_wide_clear_low <= 1'b1;
    #1;
  endtask : pulse

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rr(block_ram_pkg::CFG_B_OFS, rd);
    chk("cfg_b", 36'(block_ram_pkg::CFG_RST), 36'(rd));
    rr(block_ram_pkg::CTRL_OFS, rd);
    chk("ctrl", 36'(block_ram_pkg::MODE_RST), 36'(rd));
    rr(5'h1c, rd);
    chk("unmapped", Z, 36'(rd));
    chk("dout_b", Z, dout_b);
  endtask : t_reset

  task automatic t_rom();
    logic [35:0] w;
    rw(block_ram_pkg::IADDR_OFS, 32'h0000_0000);
    for (int k = 0; k < 16; k++) begin
      w = {1'b0, 8'(k + 90), 1'b0, 8'(3 * k + 240), 1'b0, 8'(~k), 1'b0, 8'(k ^ 165)};
      mem[k] = w;
      rw(block_ram_pkg::ILO_OFS, w[31:0]);
      rw(block_ram_pkg::IHI_OFS, 32'(w[35:32]));
    end
    for (int c = 0; c < 6; c++) begin
      setup(cf(c, 0, 0, 0, 0), cf(3, 0, 0, 0, 0), SP);
      for (int a = 3; a < 10; a += 6) begin
        opa(1'b0, a, Z, 4'hf, 2);
        chk("rom_read", xp(c, a, 1'b0), q);
      end
    end
    setup(cf(4, 0, 0, 0, 0), cf(3, 0, 0, 0, 0), TD);
    fork
      opa(1'b0, 5, Z, 4'hf, 2);
      opb(1'b0, 11, Z, 2);
    join
    chk("mixed_a", xp(4, 5, 1'b0), q);
    chk("mixed_b", xp(3, 11, 1'b0), qb);
    opa(1'b0, 2, Z, 4'hf, 1);
    chk("one_edge", xp(4, 5, 1'b0), q);
  endtask : t_rom

  task automatic t_modes();
    logic [35:0] d;
    logic [35:0] e;
    for (int m = 0; m < 3; m++) begin
      setup(cf(4, m, 0, 0, 0), cf(3, 0, 0, 0, 0), TD);
      d = {18'h0_0000, 1'b0, 8'(m + 17), 1'b0, 8'(m + 200)};
      opa(1'b0, 7, Z, 4'hf, 2);
      e = (m == 1) ? d : (m == 0) ? xp(4, 7, 1'b0) : xp(4, 6, 1'b0);
      put(4, 6, d, (m == 0) ? 4'h1 : 4'h3, 1'b0);
      opa(1'b1, 6, d, (m == 0) ? 4'h1 : 4'h3, 2);
      chk("write_out", e, q);
      opa(1'b0, 6, Z, 4'hf, 2);
      chk("byte_lanes", xp(4, 6, 1'b0), q);
    end
    setup(cf(2, 2, 0, 0, 0), cf(3, 0, 0, 0, 0), TD);
    opa(1'b0, 20, Z, 4'hf, 2);
    put(2, 21, 36'h0_0000_000c, 4'hf, 1'b0);
    opa(1'b1, 21, 36'h0_0000_000c, 4'hf, 2);
    chk("narrow_rbw", xp(2, 20, 1'b0), q);
  endtask : t_modes

  task automatic t_oreg();
    setup(cf(4, 0, 1, 0, 0), cf(3, 0, 0, 0, 0), TD);
    opa(1'b0, 3, Z, 4'hf, 3);
    chk("oreg_first", xp(4, 3, 1'b0), q);
    opa(1'b0, 4, Z, 4'hf, 2);
    chk("oreg_early", xp(4, 3, 1'b0), q);
    opa(1'b0, 5, Z, 4'hf, 3);
    chk("oreg_next", xp(4, 5, 1'b0), q);
  endtask : t_oreg

  task automatic t_clear();
    setup(cf(4, 0, 0, 0, 0), cf(3, 0, 0, 0, 0), TD);
    fork
      opa(1'b0, 1, Z, 4'hf, 2);
      opb(1'b0, 1, Z, 2);
    join
    pulse(0);
    chk("sync_no_ce", xp(4, 1, 1'b0), dout_a);
    fork
      opa(1'b0, 1, Z, 4'hf, 1);
      pulse(0);
    join
    chk("sync_clear", Z, dout_a);
    chk("other_port", xp(3, 1, 1'b0), dout_b);
    setup(cf(4, 0, 0, 1, 0), cf(3, 0, 0, 1, 0), TD);
    opa(1'b0, 2, Z, 4'hf, 2);
    pulse(1);
    chk("b_only", Z, dout_b);
    chk("a_kept", xp(4, 2, 1'b0), dout_a);
    pulse(0);
    chk("async_clear", Z, dout_a);
    fork
      opa(1'b0, 2, Z, 4'hf, 2);
      opb(1'b0, 3, Z, 2);
    join
    pulse(2);
    chk("chip_a", Z, dout_a);
    chk("chip_b", Z, dout_b);
  endtask : t_clear

  task automatic t_pseudo();
    logic [35:0] d;
    d = 36'h9_a5c3_f00f;
    setup(cf(5, 0, 0, 0, 0), cf(3, 0, 0, 0, 0), TD);
    rr(block_ram_pkg::STATUS_OFS, rd);
    chk("x36_dual", 36'h0_0000_0003, 36'(rd));
    // the refused x36 request must not touch the latch; only the read of
    // word 2 still queued from before the chip clear may land there
    opa(1'b0, 4, Z, 4'hf, 2);
    chk("x36_blocked", xp(4, 2, 1'b0), q);
    setup(cf(5, 0, 0, 0, 1), cf(5, 0, 0, 0, 1), PS);
    rr(block_ram_pkg::STATUS_OFS, rd);
    chk("x36_pseudo", 36'h0_0000_0001, 36'(rd));
    put(5, 12, d, 4'hf, 1'b1);
    opa(1'b1, 12, d, 4'hf, 2);
    opb(1'b0, 12, Z, 2);
    chk("parity_kept", xp(5, 12, 1'b1), qb);
    setup(cf(5, 0, 0, 0, 1), cf(5, 0, 0, 0, 0), PS);
    opb(1'b0, 12, Z, 2);
    chk("parity_off", xp(5, 12, 1'b0), qb);
  endtask : t_pseudo

  initial begin
    repeat (8) @(posedge clock);
    sys_rst <= 1'b0;
    t_reset();
    t_rom();
    t_modes();
    t_oreg();
    t_clear();
    t_pseudo();
    test_done();
  end
endmodule : tb_top
